/* hdl/dasp_core.sv */
// Purpose: access stretch timing, timer clock select and dual data pointers
// Assumes: one 8-bit special function register port from the core
// Notes:   the core requests moves and pointer operations by one-cycle pulses
//
// Operation
// R1: three-bit stretch field in control bits 2..0
// R2: stretch zero gives two-cycle move
// R3: each stretch unit adds one cycle
// R4: stretch resets to one
// R5: strobe width 2, else 4 per unit
// R6: bit 5 selects timer 2 clock
// R7: bit 4 selects timer 1 clock
// R8: bit 3 selects timer 0 clock
// R9: two 16-bit pointers at 0x82..0x85
// R10: select bit 0 chooses active pointer
// R11: pointer operations use the selected pointer
// R12: software toggles select by incrementing it
// R13: select bits 7..1 read zero
`timescale 1ns/1ps
`include "dasp_defs.svh"

module dasp_core #(
    parameter int CYCLE_CLOCKS = 4
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // special function register port
    input  wire logic                sfr_write,
    input  wire logic [7:0]          sfr_addr,
    input  wire logic [7:0]          sfr_wdata,
    output logic      [7:0]          sfr_rdata,
    // pointer operations
    input  wire logic                ptr_load,
    input  wire logic [15:0]         ptr_load_value,
    input  wire logic                ptr_inc,
    output logic      [15:0]         data_pointer,
    // external data move
    input  wire logic                move_start,
    input  wire logic                move_write,
    output logic                     move_busy,
    output logic                     move_done,
    output logic                     mem_read_strobe_n,
    output logic                     mem_write_strobe_n,
    output logic      [15:0]         mem_addr,
    // timer clock ticks
    output logic                     timer0_tick,
    output logic                     timer1_tick,
    output logic                     timer2_tick
);
    import dasp_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] strobe_clocks(input logic [2:0] s);
        if (s == 3'h0) begin
            strobe_clocks = `DASP_STROBE_ZERO; // R5
        end else begin
            strobe_clocks = 5'(`DASP_STROBE_UNIT * s); // R5
        end
    endfunction

    function automatic logic [7:0] move_clocks(input logic [2:0] s);
        move_clocks = 8'(CYCLE_CLOCKS * (`DASP_BASE_CYCLES + 4'(s))); // R2 R3
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]   clk_ctrl;
    logic [7:0]   next_clk_ctrl;
    logic         ptr_sel;
    logic         next_ptr_sel;
    logic [15:0]  ptr0;
    logic [15:0]  ptr1;
    logic [15:0]  next_ptr0;
    logic [15:0]  next_ptr1;
    logic [7:0]   next_sfr_rdata;
    logic [15:0]  next_data_pointer;
    logic [15:0]  active_ptr;

    assign active_ptr = ptr_sel ? ptr1 : ptr0; // R10 R11

    always_comb begin
        next_clk_ctrl = clk_ctrl;
        next_ptr_sel  = ptr_sel;
        next_ptr0     = ptr0;
        next_ptr1     = ptr1;
        if (sfr_write) begin
            unique case (sfr_addr)
                `DASP_ADDR_CLK_CTRL: next_clk_ctrl = {2'h0, sfr_wdata[5:0]}; // R1 R6 R7 R8
                `DASP_ADDR_PTR_SEL: next_ptr_sel = sfr_wdata[0]; // R12 R13
                `DASP_ADDR_PTR0_LOW: next_ptr0[7:0] = sfr_wdata; // R9
                `DASP_ADDR_PTR0_HIGH: next_ptr0[15:8] = sfr_wdata; // R9
                `DASP_ADDR_PTR1_LOW: next_ptr1[7:0] = sfr_wdata; // R9
                `DASP_ADDR_PTR1_HIGH: next_ptr1[15:8] = sfr_wdata; // R9
                default: ;
            endcase
        end
        // pointer instructions act on the selected pointer
        if (ptr_load || ptr_inc) begin
            if (ptr_sel) begin
                next_ptr1 = ptr_load ? ptr_load_value : ptr1 + 16'h0001; // R11
            end else begin
                next_ptr0 = ptr_load ? ptr_load_value : ptr0 + 16'h0001; // R11
            end
        end
        unique case (sfr_addr)
            `DASP_ADDR_CLK_CTRL: next_sfr_rdata = next_clk_ctrl;
            `DASP_ADDR_PTR_SEL: next_sfr_rdata = {7'h00, next_ptr_sel}; // R13
            `DASP_ADDR_PTR0_LOW: next_sfr_rdata = next_ptr0[7:0];
            `DASP_ADDR_PTR0_HIGH: next_sfr_rdata = next_ptr0[15:8];
            `DASP_ADDR_PTR1_LOW: next_sfr_rdata = next_ptr1[7:0];
            `DASP_ADDR_PTR1_HIGH: next_sfr_rdata = next_ptr1[15:8];
            default: next_sfr_rdata = 8'h00;
        endcase
        next_data_pointer = next_ptr_sel ? next_ptr1 : next_ptr0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_ctrl     <= `DASP_CLK_CTRL_RESET; // R4
            ptr_sel      <= 1'b0;
            ptr0         <= `DASP_PTR_RESET;
            ptr1         <= `DASP_PTR_RESET;
            sfr_rdata    <= 8'h00;
            data_pointer <= `DASP_PTR_RESET;
        end else begin
            clk_ctrl     <= next_clk_ctrl;
            ptr_sel      <= next_ptr_sel;
            ptr0         <= next_ptr0;
            ptr1         <= next_ptr1;
            sfr_rdata    <= next_sfr_rdata;
            data_pointer <= next_data_pointer;
        end
    end

    // ----------------------------------------------------------------
    // external data move sequencer
    // ----------------------------------------------------------------
    dasp_state_type state;
    dasp_state_type next_state;
    logic [7:0]     count;
    logic [7:0]     next_count;
    logic [4:0]     strobe_left;
    logic [4:0]     next_strobe_left;
    logic           dir_write;
    logic           next_dir_write;
    logic           next_busy;
    logic           next_done;
    logic           next_rd_n;
    logic           next_wr_n;
    logic [15:0]    next_mem_addr;

    always_comb begin
        next_state       = state;
        next_count       = count;
        next_strobe_left = strobe_left;
        next_dir_write   = dir_write;
        next_done        = 1'b0;
        next_mem_addr    = mem_addr;
        unique case (state)
            DASP_IDLE: begin
                if (move_start) begin
                    next_state       = DASP_STROBE;
                    next_count       = move_clocks(clk_ctrl[2:0]) - 8'h01; // R2 R3
                    next_strobe_left = strobe_clocks(clk_ctrl[2:0]) - 5'h01; // R5
                    next_dir_write   = move_write;
                    next_mem_addr    = active_ptr; // R11
                end
            end
            DASP_STROBE: begin
                next_count       = count - 8'h01;
                next_strobe_left = strobe_left - 5'h01;
                if (strobe_left == 5'h00) begin
                    next_state = DASP_TAIL;
                end
            end
            DASP_TAIL: begin
                next_count = count - 8'h01;
                if (count == 8'h01) begin
                    next_state = DASP_IDLE;
                    next_done  = 1'b1;
                end
            end
        endcase
        next_busy = (next_state != DASP_IDLE);
        next_rd_n = !(next_state == DASP_STROBE && !next_dir_write);
        next_wr_n = !(next_state == DASP_STROBE && next_dir_write);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state              <= DASP_IDLE;
            count              <= 8'h00;
            strobe_left        <= 5'h00;
            dir_write          <= 1'b0;
            move_busy          <= 1'b0;
            move_done          <= 1'b0;
            mem_read_strobe_n  <= 1'b1;
            mem_write_strobe_n <= 1'b1;
            mem_addr           <= 16'h0000;
        end else begin
            state              <= next_state;
            count              <= next_count;
            strobe_left        <= next_strobe_left;
            dir_write          <= next_dir_write;
            move_busy          <= next_busy;
            move_done          <= next_done;
            mem_read_strobe_n  <= next_rd_n;
            mem_write_strobe_n <= next_wr_n;
            mem_addr           <= next_mem_addr;
        end
    end

    // ----------------------------------------------------------------
    // timer clock selection
    // ----------------------------------------------------------------
    logic [3:0] div_count;
    logic [3:0] next_div_count;
    logic       div_tick;
    logic [2:0] next_ticks;

    assign div_tick = (div_count == `DASP_TIMER_DIV - 4'h1);

    always_comb begin
        next_div_count = div_tick ? 4'h0 : div_count + 4'h1;
        next_ticks[0]  = clk_ctrl[`DASP_BIT_T0_SEL] | div_tick; // R8
        next_ticks[1]  = clk_ctrl[`DASP_BIT_T1_SEL] | div_tick; // R7
        next_ticks[2]  = clk_ctrl[`DASP_BIT_T2_SEL] | div_tick; // R6
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count   <= 4'h0;
            timer0_tick <= 1'b0;
            timer1_tick <= 1'b0;
            timer2_tick <= 1'b0;
        end else begin
            div_count   <= next_div_count;
            timer0_tick <= next_ticks[0];
            timer1_tick <= next_ticks[1];
            timer2_tick <= next_ticks[2];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_stretch_reset: assert property (@(posedge clk) $rose(rst_n) |-> clk_ctrl[2:0] == 3'h1) // R4
        else $error("stretch not one after reset");
    chk_ctrl_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) clk_ctrl[7:6] == 2'h0) // R1
        else $error("reserved control bits set");
    chk_move_zero: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (state == DASP_IDLE && move_start && clk_ctrl[2:0] == 3'h0) |=> move_busy[*7] ##1 move_done)
        else $error("stretch zero move length wrong");
    chk_move_length: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (state == DASP_IDLE && move_start && clk_ctrl[2:0] == 3'h1) |=> move_busy[*8] ##1 move_busy[*3] ##1 move_done)
        else $error("stretch one move length wrong");
    chk_strobe_zero: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (state == DASP_IDLE && move_start && !move_write && clk_ctrl[2:0] == 3'h0)
        |=> !mem_read_strobe_n[*2] ##1 mem_read_strobe_n)
        else $error("stretch zero strobe width wrong");
    chk_strobe_one: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (state == DASP_IDLE && move_start && move_write && clk_ctrl[2:0] == 3'h1)
        |=> !mem_write_strobe_n[*4] ##1 mem_write_strobe_n)
        else $error("stretch one strobe width wrong");
    chk_t0_fast: assert property (@(posedge clk) disable iff (!rst_n) // R8
        clk_ctrl[`DASP_BIT_T0_SEL] |=> timer0_tick)
        else $error("timer 0 fast clock missing");
    chk_t1_slow: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (!clk_ctrl[`DASP_BIT_T1_SEL] && !div_tick) |=> !timer1_tick)
        else $error("timer 1 tick outside divider");
    chk_t2_slow: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (!clk_ctrl[`DASP_BIT_T2_SEL] && !div_tick) |=> !timer2_tick)
        else $error("timer 2 tick outside divider");
    chk_ptr_active: assert property (@(posedge clk) disable iff (!rst_n) // R10
        data_pointer == (ptr_sel ? ptr1 : ptr0))
        else $error("active pointer mismatch");
    chk_ptr_inc: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (ptr_inc && !ptr_load && !sfr_write && ptr_sel) |=> ptr1 == $past(ptr1) + 16'h0001)
        else $error("selected pointer not incremented");
    chk_sel_read: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (!sfr_write && sfr_addr == `DASP_ADDR_PTR_SEL) |=> sfr_rdata[7:1] == 7'h00)
        else $error("select upper bits not zero");
    chk_ptr_write: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (sfr_write && sfr_addr == `DASP_ADDR_PTR1_HIGH && !ptr_load && !ptr_inc)
        |=> ptr1[15:8] == $past(sfr_wdata))
        else $error("pointer high byte not written");

    cov_read_move: cover property (@(posedge clk) disable iff (!rst_n) move_start && !move_write ##[1:40] move_done);
    cov_write_move: cover property (@(posedge clk) disable iff (!rst_n) move_start && move_write ##[1:40] move_done);
    cov_sel_toggle: cover property (@(posedge clk) disable iff (!rst_n) !ptr_sel ##1 ptr_sel);
    cov_fast_timer: cover property (@(posedge clk) disable iff (!rst_n) clk_ctrl[`DASP_BIT_T2_SEL]);
endmodule

/* hdl/dasp_defs.svh */
// Purpose: constants of the data access stretch and dual pointer block
// Assumes: special function register addresses are 8 bits wide
// Notes:   included by the design only; the package does not include it
`ifndef DASP_DEFS_SVH
`define DASP_DEFS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define DASP_ADDR_PTR0_LOW   8'h82
`define DASP_ADDR_PTR0_HIGH  8'h83
`define DASP_ADDR_PTR1_LOW   8'h84
`define DASP_ADDR_PTR1_HIGH  8'h85
`define DASP_ADDR_PTR_SEL    8'h86
`define DASP_ADDR_CLK_CTRL   8'h8E

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DASP_BIT_T2_SEL      5
`define DASP_BIT_T1_SEL      4
`define DASP_BIT_T0_SEL      3
`define DASP_STRETCH_RESET   3'h1
`define DASP_CLK_CTRL_RESET  8'h01
`define DASP_PTR_RESET       16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DASP_BASE_CYCLES     4'h2
`define DASP_STROBE_ZERO     5'h02
`define DASP_STROBE_UNIT     5'h04
`define DASP_TIMER_DIV       4'hC

`endif

/* hdl/dasp_pkg.sv */
// Purpose: types of the data access stretch and dual pointer block
// Assumes: nothing beyond the constants header
// Notes:   states of the external data move sequencer
package dasp_pkg;
    typedef enum logic [1:0] {
        DASP_IDLE,
        DASP_STROBE,
        DASP_TAIL
    } dasp_state_type;

    typedef enum logic [1:0] {
        DASP_PTR_HOLD,
        DASP_PTR_LOAD,
        DASP_PTR_INC
    } dasp_ptr_op_type;
endpackage

/* tb/dasp_mem_model.sv */
// Purpose: data memory side of the external data move, timing the strobes
// Assumes: low active strobes; no data lines cross this interface
// Notes:   width is closed when a strobe returns high
`timescale 1ns/1ps

module dasp_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // strobes and address from the block
    input  wire logic        rd_strobe_n,
    input  wire logic        wr_strobe_n,
    input  wire logic [15:0] addr,
    // measurements
    output logic      [7:0]  width,
    output logic             was_write,
    output logic      [15:0] seen_addr,
    output logic             overlap
);
    logic [7:0] run;

    // ----------------------------------------------------------------
    // strobe timing
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run       <= 8'h00;
            width     <= 8'h00;
            was_write <= 1'b0;
            seen_addr <= 16'h0000;
            overlap   <= 1'b0;
        end else if (!rd_strobe_n || !wr_strobe_n) begin
            run       <= run + 8'h01;
            was_write <= !wr_strobe_n;
            seen_addr <= addr;
            if (!rd_strobe_n && !wr_strobe_n) begin
                overlap <= 1'b1;
            end
        end else if (run != 8'h00) begin
            width <= run;
            run   <= 8'h00;
        end
    end
endmodule

/* tb/dasp_core_tb.sv */
// Purpose: self-checking bench of the stretch timing and dual pointers
// Assumes: CYCLE_CLOCKS of 4 clocks per instruction cycle
// Notes:   register reads sample two edges after the address is set
`timescale 1ns/1ps

module dasp_core_tb;
    localparam int CC = 4;
    logic        clk, rst_n, sfr_write, ptr_load, ptr_inc, move_start, move_write;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, width;
    logic [15:0] ptr_load_value, data_pointer, mem_addr, seen_addr, v;
    logic        move_busy, move_done, rd_n, wr_n, t0, t1, t2, was_write, overlap;
    int          num_errors, comparisons, cycles, n, nb, cnt[3];

    dasp_core #(.CYCLE_CLOCKS(CC)) i_dut (
        .clk(clk), .rst_n(rst_n), .sfr_write(sfr_write), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ptr_load(ptr_load),
        .ptr_load_value(ptr_load_value), .ptr_inc(ptr_inc), .data_pointer(data_pointer),
        .move_start(move_start), .move_write(move_write), .move_busy(move_busy),
        .move_done(move_done), .mem_read_strobe_n(rd_n), .mem_write_strobe_n(wr_n),
        .mem_addr(mem_addr), .timer0_tick(t0), .timer1_tick(t1), .timer2_tick(t2)
    );

    dasp_mem_model i_mem (
        .clk(clk), .rst_n(rst_n), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .addr(mem_addr),
        .width(width), .was_write(was_write), .seen_addr(seen_addr), .overlap(overlap)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_write <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_write <= 1'b0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        sfr_addr <= a;
        repeat (2) @(posedge clk);
        #1;
        d = {8'h00, sfr_rdata};
    endtask

    task automatic pulse(input bit load);
        @(posedge clk);
        ptr_load <= load;
        ptr_inc  <= !load;
        @(posedge clk);
        ptr_load <= 1'b0;
        ptr_inc  <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // n counts cycles from the one after the taking edge through the done cycle
    task automatic do_move(input bit wr);
        @(posedge clk);
        move_start <= 1'b1;
        move_write <= wr;
        @(posedge clk);
        move_start <= 1'b0;
        #1;
        nb = int'(move_busy === 1'b1);
        n = 1;
        do begin
            @(posedge clk);
            #1;
            n++;
            nb += int'(move_busy === 1'b1);
        end while (move_done !== 1'b1 && n < 100);
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        {rst_n, sfr_write, ptr_load, ptr_inc, move_start, move_write} = 6'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        ptr_load_value = 16'h0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h82; a <= 8'h87; a++) begin
            sfr_rd(a[7:0], v);
            check("reset register", v, 16'h0000);
        end
        sfr_rd(8'h8E, v);
        check("control reset", v, 16'h0001);
        do_move(1'b0);
        check("default move cycles", n[15:0], 16'(CC * 3));
        check("default strobe width", {8'h00, width}, 16'h0004);
        sfr_wr(8'h8E, 8'hFF);
        sfr_rd(8'h8E, v);
        check("control write", v, 16'h003F);
        sfr_wr(8'h86, 8'hFF);
        sfr_rd(8'h86, v);
        check("select write", v, 16'h0001);
        sfr_wr(8'h82, 8'h34);
        sfr_wr(8'h83, 8'h12);
        sfr_wr(8'h84, 8'hCD);
        sfr_wr(8'h85, 8'hAB);
        for (int k = 0; k < 2; k++) begin
            sfr_rd(8'h86, v);
            sfr_wr(8'h86, v[7:0] + 8'h01);
            repeat (2) @(posedge clk);
            #1;
            check("toggled pointer", data_pointer, k ? 16'hABCD : 16'h1234);
        end
        for (int s = 0; s < 8; s++) begin
            sfr_wr(8'h8E, 8'(s));
            sfr_wr(8'h86, {7'h00, s[1]});
            sfr_rd(8'h8E, v);
            check("stretch field", v, 16'(s));
            do_move(s[0]);
            check("move cycles", n[15:0], 16'(CC * (2 + s)));
            check("move busy cycles", 16'(nb), 16'(CC * (2 + s) - 1));
            check("strobe width", {8'h00, width}, s == 0 ? 16'h0002 : 16'(4 * s));
            check("strobe kind", {15'h0000, was_write}, 16'(s[0]));
            check("move address", seen_addr, s[1] ? 16'hABCD : 16'h1234);
        end
        check("strobe overlap", {15'h0000, overlap}, 16'h0000);
        sfr_wr(8'h86, 8'h00);
        ptr_load_value <= 16'hA5C3;
        pulse(1'b1);
        check("loaded pointer", data_pointer, 16'hA5C3);
        sfr_rd(8'h82, v);
        check("loaded low byte", v, 16'h00C3);
        sfr_wr(8'h86, 8'h01);
        sfr_wr(8'h84, 8'hFF);
        sfr_wr(8'h85, 8'h12);
        pulse(1'b0);
        check("incremented pointer", data_pointer, 16'h1300);
        sfr_rd(8'h83, v);
        check("unselected high byte", v, 16'h00A5);
        for (int b = 0; b < 3; b++) begin
            sfr_wr(8'h8E, 8'h01 | (8'h08 << b));
            repeat (4) @(posedge clk);
            cnt = '{0, 0, 0};
            repeat (24) begin
                @(posedge clk);
                #1;
                cnt[0] += int'(t0);
                cnt[1] += int'(t1);
                cnt[2] += int'(t2);
            end
            for (int k = 0; k < 3; k++) begin
                check("timer ticks", 16'(cnt[k]), k == b ? 16'h0018 : 16'h0002);
            end
        end
        conclude();
    end
endmodule
